// ### lfs_pkg.sv
// constants shared by the lock, fuse and signature access logic
// assumes a single 25 MHz core clock; nonvolatile cells live outside
//
// Summary of operation
// - lock data in low register, lock command, store within four cycles writes locks
// - data bits 5..2 map to boot locks, zero programs that lock bit
// - only the four boot lock bits can change; other lock bits stay
// - address pointer is ignored during a lock write
// - whole program flash stays readable while lock bits program
// - eeprom write in progress blocks every flash programming operation
// - eeprom write in progress also blocks reading fuses and lock bits
// - pointer 0x0001, lock select and arm, load within three cycles reads locks
// - lock select and arm clear on read or four cycle store timeout
// - with selects cleared a load is an ordinary program memory read
// - armed lock/fuse read at pointer 0x0000 returns fuse low byte
// - armed lock/fuse read at pointer 0x0003 returns fuse high byte
// - armed lock/fuse read at pointer 0x0002 returns extended fuse byte
// - programmed bits read as zero, unprogrammed bits read as one
// - signature select and arm, load within three cycles returns signature byte
// - signature select and arm clear on read or three cycle load timeout
// - signature row holds ids, rc calibration, sensor offset, gain, lot bytes
// - 0x3c..0x3f hold ambient and hot reference voltage words in millivolts
// - each flash write lasts between 3.7 ms and 4.5 ms
// - a write in progress finishes even when core reset occurs
// - arm clears when the write ends or on four cycle timeout; stays set while writing
// - undefined command patterns in the low control bits have no effect

package lfs_pkg;

  // -------------------------------------------------------------------
  // control register layout
  // -------------------------------------------------------------------
  localparam int ARM_BIT = 0;
  localparam int LOCK_SEL_BIT = 3;
  localparam int SIG_SEL_BIT = 5;
  localparam logic [6:0] CMD_LOCK_ARM = 7'h09;
  localparam logic [6:0] CMD_SIG_ARM = 7'h21;

  // -------------------------------------------------------------------
  // timed windows
  // -------------------------------------------------------------------
  localparam logic [2:0] WIN_LOAD = 3'h4;
  localparam logic [2:0] WIN_LOAD_MIN = 3'h2;

  // -------------------------------------------------------------------
  // lock and fuse pointer values, lock byte field
  // -------------------------------------------------------------------
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  localparam int BOOT_LOCK_LSB = 2;
  localparam int BOOT_LOCK_MSB = 5;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // -------------------------------------------------------------------
  // signature row addresses
  // -------------------------------------------------------------------
  localparam logic [5:0] SIG_ID0 = 6'h00;
  localparam logic [5:0] SIG_RC_CAL = 6'h01;
  localparam logic [5:0] SIG_ID1 = 6'h02;
  localparam logic [5:0] SIG_ID2 = 6'h04;
  localparam logic [5:0] SIG_TS_OFFSET = 6'h05;
  localparam logic [5:0] SIG_TS_GAIN = 6'h07;
  localparam logic [5:0] SIG_LOT_FIRST = 6'h0e;
  localparam logic [5:0] SIG_LOT_LAST = 6'h13;
  localparam logic [5:0] SIG_VREF_AMB_LO = 6'h3c;
  localparam logic [5:0] SIG_VREF_AMB_HI = 6'h3d;
  localparam logic [5:0] SIG_VREF_HOT_LO = 6'h3e;
  localparam logic [5:0] SIG_VREF_HOT_HI = 6'h3f;

  // -------------------------------------------------------------------
  // flash write time, in tenths of a millisecond, and clock rate
  // -------------------------------------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int WRITE_MIN_MS_X10 = 37;
  localparam int WRITE_MAX_MS_X10 = 45;
  localparam int WRITE_MIN_CYC = (WRITE_MIN_MS_X10 * CLK_KHZ + 9) / 10;
  localparam int WRITE_MAX_CYC = (WRITE_MAX_MS_X10 * CLK_KHZ) / 10;
  localparam logic [16:0] WRITE_CYC_DEF = 17'(WRITE_MIN_CYC);

  // -------------------------------------------------------------------
  // sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOCK_ARM = 4'b0010,
    ST_SIG_ARM = 4'b0100,
    ST_WRITING = 4'b1000
  } lfs_state_t;

  // load source of a pending read
  typedef enum logic [1:0] {
    SRC_FLASH = 2'b00,
    SRC_FUSE = 2'b01,
    SRC_SIG = 2'b10
  } lfs_src_t;

endpackage : lfs_pkg

// ### lfs_sig_rom.sv
// signature row store, 64 bytes, registered read
// assumes address is stable in the cycle it is sampled
`timescale 1ns/1ns

module lfs_sig_rom #(
  parameter logic [7:0] ID0 = 8'h5a, // arbitrary value
  parameter logic [7:0] ID1 = 8'h6b, // arbitrary value
  parameter logic [7:0] ID2 = 8'h7c, // arbitrary value
  parameter logic [7:0] RC_CAL = 8'h40,
  parameter logic [7:0] TS_OFFSET = 8'h00,
  parameter logic [7:0] TS_GAIN = 8'h80,
  parameter logic [47:0] LOT_NUMBER = 48'h303030303030,
  parameter logic [15:0] VREF_AMB = 16'h0a00,
  parameter logic [15:0] VREF_HOT = 16'h0a00
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // read port
  input wire logic [5:0] rdAddr,
  output logic [7:0] rdData
);
  import lfs_pkg::*;

  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic [5:0] lotIdx;

  // row contents decoded from the address
  always_comb
  begin
    lotIdx = rdAddr - SIG_LOT_FIRST;
    rdData_next = BYTE_ERASED;
    case (rdAddr)
      SIG_ID0: rdData_next = ID0;
      SIG_ID1: rdData_next = ID1;
      SIG_ID2: rdData_next = ID2;
      SIG_RC_CAL: rdData_next = RC_CAL;
      SIG_TS_OFFSET: rdData_next = TS_OFFSET;
      SIG_TS_GAIN: rdData_next = TS_GAIN;
      SIG_VREF_AMB_LO: rdData_next = VREF_AMB[7:0];
      SIG_VREF_AMB_HI: rdData_next = VREF_AMB[15:8];
      SIG_VREF_HOT_LO: rdData_next = VREF_HOT[7:0];
      SIG_VREF_HOT_HI: rdData_next = VREF_HOT[15:8];
      default:
      begin
        if (rdAddr >= SIG_LOT_FIRST && rdAddr <= SIG_LOT_LAST)
        begin
          rdData_next = LOT_NUMBER[8 * lotIdx[2:0] +: 8];
        end
      end
    endcase
  end

  // output register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rdData_reg <= RESET_BYTE;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;

endmodule : lfs_sig_rom

// ### lfs_access.sv
// lock bit write, lock and fuse readback, signature row readback
// assumes core strobes are one-cycle pulses synchronous to mclk and that
// the lock and fuse cells, and the program flash data, sit outside
`timescale 1ns/1ns

module lfs_access #(
  parameter logic [16:0] WRITE_CYCLES = lfs_pkg::WRITE_CYC_DEF
) (
  // clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rstPor_n,
  // control register access from the core
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlWriteData,
  output logic [7:0] selfProgramControl,
  // core program memory operations
  input wire logic storeProgram,
  input wire logic loadProgram,
  input wire logic [15:0] addrPointer,
  input wire logic [7:0] lowDataRegister,
  output logic [7:0] loadData,
  output logic loadValid,
  // ordinary program flash read data for the current pointer
  input wire logic [7:0] progReadData,
  // eeprom status
  input wire logic eepromWriteBusy,
  // nonvolatile lock and fuse cells
  input wire logic [7:0] lockBits,
  input wire logic [7:0] fuseLowByte,
  input wire logic [7:0] fuseHighByte,
  input wire logic [7:0] fuseExtendedByte,
  output logic lockWriteStrobe,
  output logic [7:0] lockWriteData,
  output logic flashWriteBusy
);
  import lfs_pkg::*;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------

  // true when the low seven control bits match a command exactly
  function automatic logic isCmd(input logic [7:0] value, input logic [6:0] cmd);
    isCmd = (value[6:0] == cmd);
  endfunction : isCmd

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  lfs_state_t state_reg;
  lfs_state_t state_next;
  logic [2:0] win_reg;
  logic [2:0] win_next;
  logic [16:0] writeCnt_reg;
  logic [16:0] writeCnt_next;
  logic lockStb_reg;
  logic lockStb_next;
  logic [7:0] lockData_reg;
  logic [7:0] lockData_next;
  logic pendValid_reg;
  logic pendValid_next;
  lfs_src_t pendSrc_reg;
  lfs_src_t pendSrc_next;
  logic [7:0] pendData_reg;
  logic [7:0] pendData_next;
  logic [7:0] loadData_reg;
  logic [7:0] loadData_next;
  logic loadValid_reg;
  logic loadValid_next;
  logic writeActive;
  logic ctrlBlocked;
  logic armLock;
  logic armSig;
  logic startWrite;
  logic loadInWindow;
  logic sigInRange;
  logic [7:0] fuseSel;
  logic [7:0] sigData;

  // -------------------------------------------------------------------
  // signature row store
  // -------------------------------------------------------------------
  lfs_sig_rom u_sig_rom (
    .mclk(mclk),
    .rst_n(rst_n),
    .rdAddr(addrPointer[5:0]),
    .rdData(sigData)
  );

  // -------------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------------

  // eeprom or flash activity refuses new control writes
  assign writeActive = (writeCnt_reg != 17'h00000);
  assign ctrlBlocked = eepromWriteBusy || writeActive;
  // only two patterns arm this logic; anything else is dropped
  assign armLock = ctrlWrite && !ctrlBlocked && isCmd(ctrlWriteData, CMD_LOCK_ARM);
  assign armSig = ctrlWrite && !ctrlBlocked && isCmd(ctrlWriteData, CMD_SIG_ARM);
  // loads count in the first three cycles after the arm, stores in four
  assign loadInWindow = (win_reg >= WIN_LOAD_MIN);
  assign startWrite = (state_reg == ST_LOCK_ARM) && storeProgram
                      && (win_reg != 3'h0) && !eepromWriteBusy;
  assign sigInRange = (addrPointer[15:6] == 10'h000);

  // lock and fuse readback selected by pointer, stored polarity kept
  always_comb
  begin
    case (addrPointer)
      PTR_FUSE_LOW: fuseSel = fuseLowByte;
      PTR_LOCK: fuseSel = lockBits;
      PTR_FUSE_EXT: fuseSel = fuseExtendedByte;
      PTR_FUSE_HIGH: fuseSel = fuseHighByte;
      default: fuseSel = BYTE_ERASED;
    endcase
  end

  // -------------------------------------------------------------------
  // sequencer and window counter
  // -------------------------------------------------------------------

  // next state, window count and lock write request
  always_comb
  begin
    state_next = state_reg;
    win_next = (win_reg == 3'h0) ? 3'h0 : win_reg - 3'h1;
    lockStb_next = 1'b0;
    lockData_next = lockData_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (armLock)
        begin
          state_next = ST_LOCK_ARM;
          win_next = WIN_LOAD;
        end
        else if (armSig)
        begin
          state_next = ST_SIG_ARM;
          win_next = WIN_LOAD;
        end
      end
      ST_LOCK_ARM:
      begin
        if (startWrite)
        begin
          // pointer is not looked at; zeros in 5..2 program, others kept
          lockStb_next = 1'b1;
          lockData_next = lockBits;
          lockData_next[BOOT_LOCK_MSB:BOOT_LOCK_LSB] =
            lockBits[BOOT_LOCK_MSB:BOOT_LOCK_LSB]
            & lowDataRegister[BOOT_LOCK_MSB:BOOT_LOCK_LSB];
          state_next = ST_WRITING;
          win_next = 3'h0;
        end
        else if (loadProgram && loadInWindow)
        begin
          state_next = ST_IDLE;
          win_next = 3'h0;
        end
        else if (armLock || armSig)
        begin
          state_next = armLock ? ST_LOCK_ARM : ST_SIG_ARM;
          win_next = WIN_LOAD;
        end
        else if (win_next == 3'h0)
        begin
          state_next = ST_IDLE;
        end
      end
      ST_SIG_ARM:
      begin
        if (loadProgram && loadInWindow)
        begin
          state_next = ST_IDLE;
          win_next = 3'h0;
        end
        else if (armLock || armSig)
        begin
          state_next = armLock ? ST_LOCK_ARM : ST_SIG_ARM;
          win_next = WIN_LOAD;
        end
        else if (win_next < WIN_LOAD_MIN)
        begin
          state_next = ST_IDLE;
          win_next = 3'h0;
        end
      end
      ST_WRITING:
      begin
        // arm stays visible until the timer runs out
        if (writeCnt_reg == 17'h00001)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        win_next = 3'h0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      win_reg <= 3'h0;
      lockStb_reg <= 1'b0;
      lockData_reg <= BYTE_ERASED;
    end
    else
    begin
      state_reg <= state_next;
      win_reg <= win_next;
      lockStb_reg <= lockStb_next;
      lockData_reg <= lockData_next;
    end
  end

  // -------------------------------------------------------------------
  // flash write timer
  // -------------------------------------------------------------------

  // fixed duration inside the allowed band, counted on mclk
  always_comb
  begin
    if (startWrite)
    begin
      writeCnt_next = WRITE_CYCLES;
    end
    else if (writeActive)
    begin
      writeCnt_next = writeCnt_reg - 17'h00001;
    end
    else
    begin
      writeCnt_next = writeCnt_reg;
    end
  end

  // only power-on reset clears the timer, core reset lets it finish
  always_ff @(posedge mclk)
  begin
    if (!rstPor_n)
    begin
      writeCnt_reg <= 17'h00000;
    end
    else
    begin
      writeCnt_reg <= writeCnt_next;
    end
  end

  // -------------------------------------------------------------------
  // load path
  // -------------------------------------------------------------------

  // choose what a load returns and stage it one cycle
  always_comb
  begin
    pendValid_next = loadProgram;
    pendSrc_next = SRC_FLASH;
    pendData_next = progReadData;
    if (loadProgram && loadInWindow && !eepromWriteBusy)
    begin
      if (state_reg == ST_LOCK_ARM)
      begin
        pendSrc_next = SRC_FUSE;
        pendData_next = fuseSel;
      end
      else if (state_reg == ST_SIG_ARM)
      begin
        pendSrc_next = sigInRange ? SRC_SIG : SRC_FUSE;
        pendData_next = BYTE_ERASED;
      end
    end
    // a refused or late load falls back to ordinary flash data
    if (eepromWriteBusy && state_reg != ST_IDLE)
    begin
      pendSrc_next = SRC_FLASH;
    end
    loadValid_next = pendValid_reg;
    loadData_next = (pendSrc_reg == SRC_SIG) ? sigData : pendData_reg;
  end

  // load registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pendValid_reg <= 1'b0;
      pendSrc_reg <= SRC_FLASH;
      pendData_reg <= RESET_BYTE;
      loadValid_reg <= 1'b0;
      loadData_reg <= RESET_BYTE;
    end
    else
    begin
      pendValid_reg <= pendValid_next;
      pendSrc_reg <= pendSrc_next;
      pendData_reg <= pendData_next;
      loadValid_reg <= loadValid_next;
      loadData_reg <= loadData_next;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------

  // control register readback: selects while armed, arm doubles as busy
  always_comb
  begin
    selfProgramControl = 8'h00;
    selfProgramControl[ARM_BIT] = (state_reg != ST_IDLE) || writeActive;
    selfProgramControl[LOCK_SEL_BIT] = (state_reg == ST_LOCK_ARM);
    selfProgramControl[SIG_SEL_BIT] = (state_reg == ST_SIG_ARM);
  end

  assign loadData = loadData_reg;
  assign loadValid = loadValid_reg;
  assign lockWriteStrobe = lockStb_reg;
  assign lockWriteData = lockData_reg;
  assign flashWriteBusy = writeActive;

endmodule : lfs_access

// ### lfs_access_sva.sv
// port assertions for the lock, fuse and signature access block
// assumes one mclk domain; bound into every lfs_access instance
`timescale 1ns/1ns

module lfs_access_sva #(
  parameter logic [16:0] WRITE_CYCLES = 17'h00008
) (
  // clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rstPor_n,
  // core side
  input wire logic ctrlWrite,
  input wire logic [7:0] selfProgramControl,
  input wire logic storeProgram,
  input wire logic loadProgram,
  input wire logic [7:0] lowDataRegister,
  input wire logic loadValid,
  input wire logic eepromWriteBusy,
  // cell side
  input wire logic [7:0] lockBits,
  input wire logic lockWriteStrobe,
  input wire logic [7:0] lockWriteData,
  input wire logic flashWriteBusy
);
  logic [16:0] busyCnt_reg;
  logic [16:0] busyCnt_next;

  // counts the busy cycles of the running flash write
  always_comb
  begin
    busyCnt_next = flashWriteBusy ? busyCnt_reg + 17'h00001 : 17'h00000;
  end
  always_ff @(posedge mclk)
  begin
    busyCnt_reg <= rstPor_n ? busyCnt_next : 17'h00000;
  end

  // write launch, data and duration
  store_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    storeProgram && selfProgramControl[3] && !eepromWriteBusy
    |=> lockWriteStrobe && flashWriteBusy)
    else $error("store in lock window did not start a write");
  strobe_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lockWriteStrobe |-> $past(storeProgram) && $past(selfProgramControl[3])
    && !$past(eepromWriteBusy))
    else $error("lock write without an armed store");
  lock_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lockWriteStrobe |-> lockWriteData == ($past(lockBits) & ($past(lowDataRegister) | 8'hc3)))
    else $error("lock write data wrong");
  busy_length_a: assert property (@(posedge mclk) disable iff (!rstPor_n)
    $fell(flashWriteBusy) |-> busyCnt_reg == WRITE_CYCLES)
    else $error("flash write length wrong");
  busy_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    flashWriteBusy |-> selfProgramControl[0] && !selfProgramControl[3])
    else $error("arm bit low or lock select high during write");
  // read latency, windows and blocking
  load_latency_a: assert property (@(posedge mclk) disable iff (!rst_n)
    loadProgram |-> ##2 loadValid)
    else $error("load answer not two cycles later");
  lock_window_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(selfProgramControl[3]) && !ctrlWrite ##1 !ctrlWrite ##1 !ctrlWrite ##1 !ctrlWrite
    |=> !selfProgramControl[3])
    else $error("lock arm outlived four cycles");
  sig_window_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(selfProgramControl[5]) && !ctrlWrite ##1 !ctrlWrite ##1 !ctrlWrite
    |=> !selfProgramControl[5])
    else $error("signature arm outlived three cycles");
  eeprom_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrlWrite && eepromWriteBusy && selfProgramControl == 8'h00 |=> selfProgramControl == 8'h00)
    else $error("control write taken while eeprom busy");
endmodule : lfs_access_sva

bind lfs_access lfs_access_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (
  .mclk(mclk), .rst_n(rst_n), .rstPor_n(rstPor_n), .ctrlWrite(ctrlWrite),
  .selfProgramControl(selfProgramControl), .storeProgram(storeProgram),
  .loadProgram(loadProgram), .lowDataRegister(lowDataRegister), .loadValid(loadValid),
  .eepromWriteBusy(eepromWriteBusy), .lockBits(lockBits), .lockWriteStrobe(lockWriteStrobe),
  .lockWriteData(lockWriteData), .flashWriteBusy(flashWriteBusy)
);

// ### lfs_nv_model.sv
// model of the lock and fuse cells and of program flash read data
// assumes lock writes arrive as one-cycle strobes on mclk
`timescale 1ns/1ns

module lfs_nv_model #(
  parameter logic [7:0] FUSE_LOW = 8'h62,
  parameter logic [7:0] FUSE_HIGH = 8'hdf,
  parameter logic [7:0] FUSE_EXT = 8'hf9
) (
  // clock
  input wire logic mclk,
  // access block side
  input wire logic [15:0] addrPointer,
  input wire logic lockWriteStrobe,
  input wire logic [7:0] lockWriteData,
  output logic [7:0] lockBits,
  output logic [7:0] fuseLowByte,
  output logic [7:0] fuseHighByte,
  output logic [7:0] fuseExtendedByte,
  output logic [7:0] progReadData
);
  logic [7:0] lockCell_reg = 8'hff;
  logic [7:0] lockCell_next;

  // cells hold zero when programmed and can only be programmed
  always_comb
  begin
    lockCell_next = lockCell_reg;
    if (lockWriteStrobe)
    begin
      lockCell_next = lockCell_reg & lockWriteData;
    end
  end
  always_ff @(posedge mclk) lockCell_reg <= lockCell_next;

  // cell values and flash data, which stays readable during lock writes
  assign lockBits = lockCell_reg;
  assign fuseLowByte = FUSE_LOW;
  assign fuseHighByte = FUSE_HIGH;
  assign fuseExtendedByte = FUSE_EXT;
  assign progReadData = addrPointer[7:0] ^ 8'ha5;
endmodule : lfs_nv_model

// ### tb.sv
// self-checking bench for lfs_access with the cell model as far side
// assumes default signature row contents and a shortened write time
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin nMismatch++; \
  $display("FAIL %s expected %h seen %h", nm, ex, gt); end end

module tb;
  import lfs_pkg::*;
  localparam logic [16:0] WR = 17'h00008;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rstPor_n = 1'b0;
  logic ctrlWrite = 1'b0;
  logic [7:0] ctrlWriteData = 8'h00;
  logic storeProgram = 1'b0;
  logic loadProgram = 1'b0;
  logic [15:0] addrPointer = 16'h0000;
  logic [7:0] lowDataRegister = 8'hff;
  logic eepromWriteBusy = 1'b0;
  logic [7:0] selfProgramControl, loadData, progReadData, lockBits, lockWriteData;
  logic [7:0] fuseLowByte, fuseHighByte, fuseExtendedByte;
  logic loadValid, lockWriteStrobe, flashWriteBusy;
  int nMismatch = 0;
  int checksDone = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  lfs_access #(.WRITE_CYCLES(WR)) u_dut (.mclk(mclk), .rst_n(rst_n), .rstPor_n(rstPor_n),
    .ctrlWrite(ctrlWrite), .ctrlWriteData(ctrlWriteData), .selfProgramControl(selfProgramControl),
    .storeProgram(storeProgram), .loadProgram(loadProgram), .addrPointer(addrPointer),
    .lowDataRegister(lowDataRegister), .loadData(loadData), .loadValid(loadValid),
    .progReadData(progReadData), .eepromWriteBusy(eepromWriteBusy), .lockBits(lockBits),
    .fuseLowByte(fuseLowByte), .fuseHighByte(fuseHighByte), .fuseExtendedByte(fuseExtendedByte),
    .lockWriteStrobe(lockWriteStrobe), .lockWriteData(lockWriteData),
    .flashWriteBusy(flashWriteBusy));
  lfs_nv_model u_nv (.mclk(mclk), .addrPointer(addrPointer), .lockWriteStrobe(lockWriteStrobe),
    .lockWriteData(lockWriteData), .lockBits(lockBits), .fuseLowByte(fuseLowByte),
    .fuseHighByte(fuseHighByte), .fuseExtendedByte(fuseExtendedByte),
    .progReadData(progReadData));

  // verdict and end of run
  task automatic wrap_up;
    if (nMismatch == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // helpers for core operations, each starting just after a clock edge
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
    end
  endtask : cyc
  task automatic ctrl(input logic [7:0] v);
    ctrlWrite = 1'b1;
    ctrlWriteData = v;
    cyc(1);
    ctrlWrite = 1'b0;
  endtask : ctrl
  task automatic store(input logic [7:0] d);
    storeProgram = 1'b1;
    lowDataRegister = d;
    cyc(1);
    storeProgram = 1'b0;
  endtask : store
  task automatic load(input logic [15:0] p, output logic [7:0] d);
    addrPointer = p;
    loadProgram = 1'b1;
    cyc(1);
    loadProgram = 1'b0;
    for (int i = 0; i < 4 && loadValid !== 1'b1; i++) cyc(1);
    if (loadValid === 1'b1) d = loadData;
    else
    begin
      nMismatch++;
      wrap_up();
    end
  endtask : load

  // lock and fuse readback by pointer, then a plain read
  task automatic s_fuse;
    logic [15:0] p[5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005};
    logic [7:0] e[5] = '{8'h62, 8'hff, 8'hf9, 8'hdf, 8'hff};
    logic [7:0] d;
    for (int i = 0; i < 5; i++)
    begin
      ctrl((i == 0) ? 8'h89 : 8'h09);
      load(p[i], d);
      `CHK("fuse read", e[i], d)
    end
    `CHK("control", 8'h00, selfProgramControl)
    load(16'h0001, d);
    `CHK("plain read", 8'ha4, d)
  endtask : s_fuse

  // signature row readback
  task automatic s_sig;
    logic [15:0] p[8] = '{16'h01, 16'h05, 16'h07, 16'h3c, 16'h3d, 16'h0e, 16'h03, 16'h40};
    logic [7:0] e[8] = '{8'h40, 8'h00, 8'h80, 8'h00, 8'h0a, 8'h30, 8'hff, 8'hff};
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      ctrl(8'h21);
      load(p[i], d);
      `CHK("signature", e[i], d)
    end
    `CHK("control", 8'h00, selfProgramControl)
  endtask : s_sig

  // window edges: last load slot, late load, timeouts
  task automatic s_window;
    logic [7:0] d;
    ctrl(8'h09);
    cyc(2);
    load(16'h0000, d);
    `CHK("third cycle load", 8'h62, d)
    ctrl(8'h09);
    cyc(3);
    load(16'h0000, d);
    `CHK("late load", 8'ha5, d)
    `CHK("control", 8'h00, selfProgramControl)
    ctrl(8'h09);
    cyc(3);
    `CHK("lock armed", 8'h09, selfProgramControl)
    cyc(1);
    `CHK("lock timeout", 8'h00, selfProgramControl)
    ctrl(8'h21);
    cyc(2);
    `CHK("sig armed", 8'h21, selfProgramControl)
    cyc(1);
    `CHK("sig timeout", 8'h00, selfProgramControl)
  endtask : s_window

  // undefined command patterns do nothing
  task automatic s_undef;
    logic [7:0] bad[4] = '{8'h05, 8'h03, 8'h11, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      ctrl(bad[i]);
      `CHK("control", 8'h00, selfProgramControl)
      store(8'h00);
      `CHK("strobe", 1'b0, lockWriteStrobe)
    end
  endtask : s_undef

  // eeprom write blocks arming, special reads and stores
  task automatic s_eeprom;
    logic [7:0] d;
    eepromWriteBusy = 1'b1;
    ctrl(8'h09);
    `CHK("control", 8'h00, selfProgramControl)
    eepromWriteBusy = 1'b0; // eeprom idle before the control write
    ctrl(8'h09);
    eepromWriteBusy = 1'b1;
    load(16'h0002, d);
    `CHK("blocked read", 8'ha7, d)
    eepromWriteBusy = 1'b0;
    cyc(4); // eeprom idle before the control write
    ctrl(8'h09);
    eepromWriteBusy = 1'b1;
    store(8'h00);
    `CHK("strobe", 1'b0, lockWriteStrobe)
    eepromWriteBusy = 1'b0;
    cyc(4);
  endtask : s_eeprom

  // two lock writes, reads and reset during the first, timed second
  task automatic s_write;
    logic [7:0] d;
    int n;
    addrPointer = 16'h1234;
    ctrl(8'h09);
    store(8'he7);
    `CHK("strobe", 1'b1, lockWriteStrobe)
    `CHK("lock data", 8'he7, lockWriteData)
    `CHK("arm bit", 1'b1, selfProgramControl[0])
    load(16'h0010, d);
    `CHK("read while writing", 8'hb5, d)
    ctrl(8'h09);
    `CHK("lock select", 1'b0, selfProgramControl[3])
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    `CHK("busy after reset", 1'b1, flashWriteBusy)
    for (n = 0; n < 20 && flashWriteBusy !== 1'b0; n++) cyc(1);
    `CHK("busy end", 1'b0, flashWriteBusy)
    ctrl(8'h09);
    store(8'h00);
    `CHK("lock data", 8'hc3, lockWriteData)
    for (n = 0; n < 20 && flashWriteBusy === 1'b1; n++) cyc(1);
    `CHK("busy cycles", int'(WR), n)
    `CHK("control", 8'h00, selfProgramControl)
    ctrl(8'h09);
    load(16'h0001, d);
    `CHK("lock read", 8'hc3, d)
  endtask : s_write

  // main sequence
  initial
  begin
    cyc(6);
    rst_n = 1'b1;
    rstPor_n = 1'b1;
    `CHK("control", 8'h00, selfProgramControl)
    `CHK("busy", 1'b0, flashWriteBusy)
    s_fuse();
    s_sig();
    s_window();
    s_undef();
    s_eeprom();
    s_write();
    wrap_up();
  end
endmodule : tb
